/* bench/tb_top.sv */
// self-checking bench of the error interrupt block over apb
// assumes the link master model and the bound checker
`timescale 1ns/10ps
`include "uei_consts.vh"
module tb_top;
    localparam logic [31:0] EN = `UEI_OFF_ENABLES;
    localparam logic [31:0] PD = `UEI_OFF_PENDING;
    localparam logic [31:0] CT = `UEI_OFF_CONTROL;
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rdat;
    logic        txQueueWrite = 1'b0, txQueueFull = 1'b0, runTx = 1'b0, runRx = 1'b0;
    logic        rxQueueRead = 1'b0, rxQueueEmpty = 1'b0, rerr;
    wire         pready, pslverr, txLinkClock, rxLinkClock, cpuErrorIrq;
    wire         txInterfaceEnable, rxInterfaceEnable;
    wire  [31:0] prdata;
    int          n_mismatch = 0, n_tests = 0, sh;

    always #5 ref_clk = ~ref_clk;

    uei_error_irq i_uei_error_irq (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .txLinkClock, .rxLinkClock, .txQueueWrite,
        .txQueueFull, .rxQueueRead, .rxQueueEmpty, .txInterfaceEnable, .rxInterfaceEnable,
        .cpuErrorIrq);
    uei_link_master i_uei_link_master (.runTx, .runRx, .txLinkClock, .rxLinkClock);

    task automatic stop_test;
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t no pready", $time);
            stop_test;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk(rdat, x);
    endtask

    // interrupt lags the pending bit, so let a few cycles settle first
    task automatic irq(input logic x);
        repeat (3) @(negedge ref_clk);
        chk({31'h0, cpuErrorIrq}, {31'h0, x});
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(EN, 32'h0);
        rd(PD, 32'h0);
        irq(1'b0);
        wr(EN, 32'hffff_ffff);
        rd(EN, `UEI_EVENT_MASK);
        wr(PD, 32'hffff_ffff);
        rd(PD, 32'h0);
        irq(1'b0);
        wr(32'h10, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        rd(EN, `UEI_EVENT_MASK);
        rd(32'h10, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(EN, 32'h0001_0000);
        @(posedge ref_clk);
        txQueueWrite <= 1'b1;
        txQueueFull <= 1'b1;
        @(posedge ref_clk);
        txQueueWrite <= 1'b0;
        wr(PD, 32'h0001_0000);
        rd(PD, 32'h0001_0000);
        irq(1'b1);
        @(posedge ref_clk);
        txQueueFull <= 1'b0;
        rd(PD, 32'h0);
        irq(1'b0);
        wr(EN, 32'h1);
        @(posedge ref_clk);
        rxQueueRead <= 1'b1;
        rxQueueEmpty <= 1'b1;
        @(posedge ref_clk);
        rxQueueRead <= 1'b0;
        rd(PD, 32'h1);
        irq(1'b1);
        @(posedge ref_clk);
        rxQueueEmpty <= 1'b0;
        rd(PD, 32'h1);
        @(posedge ref_clk);
        rxQueueRead <= 1'b1;
        @(posedge ref_clk);
        rxQueueRead <= 1'b0;
        rd(PD, 32'h0);
        irq(1'b0);
        // pass 0 is receive, pass 1 transmit; fields sit 16 bits apart
        for (int d = 0; d < 2; d++) begin
            sh = d * 16;
            wr(`UEI_OFF_CLKDET, 32'h20 << sh);
            wr(EN, 32'h2 << sh);
            runRx <= (d == 0);
            runTx <= (d == 1);
            repeat (70) @(posedge ref_clk);
            runRx <= 1'b0;
            runTx <= 1'b0;
            repeat (100) @(posedge ref_clk);
            rd(PD, 32'h4 << sh);
            irq(1'b0);
            wr(CT, 32'h1 << d);
            repeat (50) @(posedge ref_clk);
            chk({30'h0, txInterfaceEnable, rxInterfaceEnable}, 32'h1 << d);
            rd(PD, 32'h6 << sh);
            irq(1'b1);
            wr(PD, 32'h4 << sh);
            rd(PD, 32'h2 << sh);
            wr(PD, 32'h0);
            rd(PD, 32'h2 << sh);
            wr(PD, 32'h2 << sh);
            rd(PD, 32'h0);
            irq(1'b0);
            wr(CT, 32'h0);
            // count of 3: the failure lands on the access edge of the next write
            wr(`UEI_OFF_CLKDET, 32'h3 << sh);
            wr(CT, 32'h1 << d);
            wr(PD, 32'h2 << sh);
            rd(PD, 32'h2 << sh);
            wr(PD, 32'h2 << sh);
            rd(PD, 32'h0);
            wr(CT, 32'h0);
        end
        stop_test;
    end
endmodule // tb_top

/* bench/uei_error_irq_sva.sv */
// checker of the error interrupt block, top ports only
// assumes the apb master on ref_clk and the bit layout of uei_consts.vh
`timescale 1ns/10ps
`include "uei_consts.vh"
module uei_error_irq_sva (
    // clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // queues, enables, interrupt
    input wire        txQueueWrite,
    input wire        txQueueFull,
    input wire        rxQueueRead,
    input wire        rxQueueEmpty,
    input wire        txInterfaceEnable,
    input wire        rxInterfaceEnable,
    input wire        cpuErrorIrq
);
    logic [31:0] enShadow_r;
    wire         acc = psel && penable;
    wire         known = paddr inside {`UEI_OFF_ENABLES, `UEI_OFF_PENDING,
                                       `UEI_OFF_CONTROL, `UEI_OFF_CLKDET};

    // enables are not visible at the ports, so keep a copy from the writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            enShadow_r <= 32'h0;
        else if (acc && pwrite && paddr == `UEI_OFF_ENABLES)
            enShadow_r <= pwdata & `UEI_EVENT_MASK;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_bad_addr: assert property (acc && !known |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_rsvd_zero: assert property (acc && !pwrite && paddr inside {`UEI_OFF_ENABLES,
        `UEI_OFF_PENDING} |-> (prdata & ~`UEI_EVENT_MASK) == 32'h0)
        else $error("reserved bits read non-zero");
    a_ctl_follow: assert property (acc && pwrite && paddr == `UEI_OFF_CONTROL |=>
        {txInterfaceEnable, rxInterfaceEnable} == $past(pwdata[1:0]))
        else $error("interface enables do not follow control write");
    a_irq_masked: assert property (enShadow_r == 32'h0 |=> !cpuErrorIrq)
        else $error("interrupt with all enables clear");
    a_tx_stall: assert property (txQueueWrite && txQueueFull ##1 enShadow_r[16]
        |=> cpuErrorIrq)
        else $error("no interrupt two cycles after tx stall");
    a_tx_unstall: assert property ((enShadow_r == 32'h0001_0000 && !txQueueFull)
        ##1 enShadow_r == 32'h0001_0000 |=> !cpuErrorIrq)
        else $error("tx stall interrupt stays after space frees");
    a_rx_stall: assert property (rxQueueRead && rxQueueEmpty ##1 enShadow_r[0]
        |=> cpuErrorIrq)
        else $error("no interrupt two cycles after rx stall");
    a_rx_unstall: assert property (rxQueueRead && !rxQueueEmpty
        ##1 enShadow_r == 32'h1 |=> !cpuErrorIrq)
        else $error("rx stall interrupt stays after data read");
endmodule // uei_error_irq_sva

bind uei_error_irq uei_error_irq_sva i_uei_error_irq_sva (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .txQueueWrite, .txQueueFull, .rxQueueRead, .rxQueueEmpty,
    .txInterfaceEnable, .rxInterfaceEnable, .cpuErrorIrq);

/* bench/uei_link_master.sv */
// link master model: drives both link clocks of the cell port
// assumes the bench requests clock bursts through the run inputs
`timescale 1ns/10ps
module uei_link_master (
    // burst requests
    input  wire  runTx,
    input  wire  runRx,
    // link clocks
    output logic txLinkClock,
    output logic rxLinkClock
);
    // 160 ns period, rests low outside bursts; odd offset keeps it off ref_clk edges
    initial begin
        txLinkClock = 1'b0;
        rxLinkClock = 1'b0;
        #3.3;
        forever begin
            #80;
            txLinkClock = runTx ? ~txLinkClock : 1'b0;
            rxLinkClock = runRx ? ~rxLinkClock : 1'b0;
        end
    end
endmodule // uei_link_master

/* logic/uei_clk_watch.v */
// link clock watcher: finds rising edges of one link clock and times gaps
// assumes the link clock is asynchronous and slower than half of clk
`timescale 1ns/10ps
`include "uei_consts.vh"

module uei_clk_watch (
    // clock and reset
    input  wire                  clk,
    input  wire                  rstSync_n,
    // link side
    input  wire                  linkClock,
    // control
    input  wire                  ifEnable,
    input  wire [`UEI_CNT_W-1:0] timeoutCount,
    // events
    output wire                  edgePulse,
    output wire                  failPulse
);

    reg                  syncA_r;
    reg                  syncB_r;
    reg                  prev_r;
    reg [`UEI_CNT_W-1:0] gap_r;
    reg [`UEI_CNT_W-1:0] gap_nxt;

    // syncA_r is read by syncB_r alone
    always @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
            prev_r  <= 1'b0;
            gap_r   <= `UEI_CNT_ZERO;
        end else begin
            syncA_r <= linkClock;
            syncB_r <= syncA_r;
            prev_r  <= syncB_r;
            gap_r   <= gap_nxt;
        end
    end

    // low-to-high transition only
    assign edgePulse = syncB_r & ~prev_r;

    // gap counter holds at the limit so the failure fires once per gap
    always @* begin
        gap_nxt = gap_r;
        if (edgePulse || !ifEnable || timeoutCount == `UEI_CNT_ZERO) begin
            gap_nxt = `UEI_CNT_ZERO;
        end else if (gap_r != timeoutCount) begin
            gap_nxt = gap_r + `UEI_CNT_ONE;
        end
    end

    // zero count disables detection
    assign failPulse = ifEnable && (timeoutCount != `UEI_CNT_ZERO) && !edgePulse
                       && (gap_r == timeoutCount - `UEI_CNT_ONE);

endmodule // uei_clk_watch

/* logic/uei_error_irq.v */
// error interrupt logic of the cell port: enables, pending bits, interrupt
// assumes an apb master on ref_clk and queue status from logic on ref_clk
`timescale 1ns/10ps
`include "uei_consts.vh"

module uei_error_irq (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire [31:0] prdata,
    output wire        pslverr,
    // link clocks from the master controller
    input  wire        txLinkClock,
    input  wire        rxLinkClock,
    // queue status from the cell queues
    input  wire        txQueueWrite,
    input  wire        txQueueFull,
    input  wire        rxQueueRead,
    input  wire        rxQueueEmpty,
    // interface enables seen by the cell paths
    output wire        txInterfaceEnable,
    output wire        rxInterfaceEnable,
    // interrupt to the cpu
    output wire        cpuErrorIrq
);

    // address decode, shared by the read and write paths
    function [`UEI_SEL_W-1:0] regSel;
        input [31:0] addr;
        begin
            case (addr)
                `UEI_OFF_ENABLES: regSel = `UEI_SEL_ENABLES;
                `UEI_OFF_PENDING: regSel = `UEI_SEL_PENDING;
                `UEI_OFF_CONTROL: regSel = `UEI_SEL_CONTROL;
                `UEI_OFF_CLKDET:  regSel = `UEI_SEL_CLKDET;
                default:          regSel = `UEI_SEL_NONE;
            endcase
        end
    endfunction

    // reset release
    reg                   rstMeta_r;
    reg                   rstSync_r;
    wire                  rstSync_n;

    // registers
    reg  [31:0]           enables_r;
    reg  [31:0]           control_r;
    reg  [31:0]           clkDetect_r;
    reg  [31:0]           prdata_r;
    reg                   slvErr_r;
    reg                   irq_r;

    // pending bits
    reg                   txClockPresentPending_r;
    reg                   txClockFailedPending_r;
    reg                   txQueueStallPending_r;
    reg                   rxClockPresentPending_r;
    reg                   rxClockFailedPending_r;
    reg                   rxQueueStallPending_r;
    reg                   txQueueStall_nxt;
    reg                   rxQueueStall_nxt;

    // decode and events
    wire [`UEI_SEL_W-1:0] sel;
    wire                  setupPhase;
    wire                  writeDone;
    wire                  wrEnables;
    wire                  wrPending;
    wire                  wrControl;
    wire                  wrClkDetect;
    wire [31:0]           pendingWord;
    wire [`UEI_NDIR-1:0]  linkClkVec;
    wire [`UEI_NDIR-1:0]  ifEnVec;
    wire [`UEI_CNT_W-1:0] cntVec [0:`UEI_NDIR-1];
    wire [`UEI_NDIR-1:0]  edgeVec;
    wire [`UEI_NDIR-1:0]  failVec;
    wire                  clrTxPresent;
    wire                  clrTxFailed;
    wire                  clrRxPresent;
    wire                  clrRxFailed;

    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    assign rstSync_n = rstSync_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign sel        = regSel(paddr);
    assign setupPhase = psel & ~penable;
    assign writeDone  = psel & penable & pwrite;

    assign wrEnables   = writeDone & sel[`UEI_SI_ENABLES];
    assign wrPending   = writeDone & sel[`UEI_SI_PENDING];
    assign wrControl   = writeDone & sel[`UEI_SI_CONTROL];
    assign wrClkDetect = writeDone & sel[`UEI_SI_CLKDET];

    // zero wait states: read data is caught in the setup cycle
    assign pready  = psel & penable;
    assign prdata  = prdata_r;
    assign pslverr = slvErr_r & psel & penable;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // masking at the write keeps reserved bits zero on readback
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            enables_r   <= `UEI_RST_WORD;
            control_r   <= `UEI_RST_WORD;
            clkDetect_r <= `UEI_RST_WORD;
        end else begin
            if (wrEnables) begin
                enables_r <= pwdata & `UEI_EVENT_MASK;
            end
            if (wrControl) begin
                control_r <= pwdata & `UEI_CTRL_MASK;
            end
            if (wrClkDetect) begin
                clkDetect_r <= pwdata & `UEI_CLKDET_MASK;
            end
        end
    end

    assign txInterfaceEnable = control_r[`UEI_CTRL_TX_EN];
    assign rxInterfaceEnable = control_r[`UEI_CTRL_RX_EN];

    // ------------------------------------------------------------
    // link clock watchers, one per direction
    // ------------------------------------------------------------
    assign linkClkVec[`UEI_DIR_TX] = txLinkClock;
    assign linkClkVec[`UEI_DIR_RX] = rxLinkClock;
    assign ifEnVec[`UEI_DIR_TX]    = txInterfaceEnable;
    assign ifEnVec[`UEI_DIR_RX]    = rxInterfaceEnable;
    assign cntVec[`UEI_DIR_TX]     = clkDetect_r[`UEI_TXCNT_MSB:`UEI_TXCNT_LSB];
    assign cntVec[`UEI_DIR_RX]     = clkDetect_r[`UEI_RXCNT_MSB:`UEI_RXCNT_LSB];

    genvar d;
    generate
        for (d = 0; d < `UEI_NDIR; d = d + 1) begin : gWatch
            uei_clk_watch uWatch (
                .clk          (ref_clk),
                .rstSync_n    (rstSync_n),
                .linkClock    (linkClkVec[d]),
                .ifEnable     (ifEnVec[d]),
                .timeoutCount (cntVec[d]),
                .edgePulse    (edgeVec[d]),
                .failPulse    (failVec[d])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // clock status pending bits, write one to clear
    // ------------------------------------------------------------
    assign clrTxPresent = wrPending & pwdata[`UEI_BIT_TX_CP];
    assign clrTxFailed  = wrPending & pwdata[`UEI_BIT_TX_CF];
    assign clrRxPresent = wrPending & pwdata[`UEI_BIT_RX_CP];
    assign clrRxFailed  = wrPending & pwdata[`UEI_BIT_RX_CF];

    // set is tested first so an edge in the clearing cycle is kept
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            txClockPresentPending_r <= 1'b0;
            txClockFailedPending_r  <= 1'b0;
            rxClockPresentPending_r <= 1'b0;
            rxClockFailedPending_r  <= 1'b0;
        end else begin
            // edges count whether or not the interface is enabled
            if (edgeVec[`UEI_DIR_TX]) begin
                txClockPresentPending_r <= 1'b1;
            end else if (clrTxPresent) begin
                txClockPresentPending_r <= 1'b0;
            end

            // watcher only fails while the interface is enabled
            if (failVec[`UEI_DIR_TX]) begin
                txClockFailedPending_r <= 1'b1;
            end else if (clrTxFailed) begin
                txClockFailedPending_r <= 1'b0;
            end

            if (edgeVec[`UEI_DIR_RX]) begin
                rxClockPresentPending_r <= 1'b1;
            end else if (clrRxPresent) begin
                rxClockPresentPending_r <= 1'b0;
            end

            if (failVec[`UEI_DIR_RX]) begin
                rxClockFailedPending_r <= 1'b1;
            end else if (clrRxFailed) begin
                rxClockFailedPending_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // queue stall pending bits, hardware owned
    // ------------------------------------------------------------
    // bits follow the queue, so software writes never reach them
    always @* begin
        txQueueStall_nxt = txQueueStallPending_r;
        if (txQueueWrite && txQueueFull) begin
            txQueueStall_nxt = 1'b1;
        end else if (!txQueueFull) begin
            txQueueStall_nxt = 1'b0;
        end
    end

    // a stalled read clears only when data is there and taken
    always @* begin
        rxQueueStall_nxt = rxQueueStallPending_r;
        if (rxQueueRead && rxQueueEmpty) begin
            rxQueueStall_nxt = 1'b1;
        end else if (rxQueueRead && !rxQueueEmpty) begin
            rxQueueStall_nxt = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            txQueueStallPending_r <= 1'b0;
            rxQueueStallPending_r <= 1'b0;
        end else begin
            txQueueStallPending_r <= txQueueStall_nxt;
            rxQueueStallPending_r <= rxQueueStall_nxt;
        end
    end

    // ------------------------------------------------------------
    // pending word as software sees it
    // ------------------------------------------------------------
    assign pendingWord = {
        13'h0000,
        txClockPresentPending_r,
        txClockFailedPending_r,
        txQueueStallPending_r,
        13'h0000,
        rxClockPresentPending_r,
        rxClockFailedPending_r,
        rxQueueStallPending_r
    };

    // ------------------------------------------------------------
    // read data and error, captured in the setup cycle
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            prdata_r <= `UEI_RST_WORD;
            slvErr_r <= 1'b0;
        end else if (setupPhase) begin
            slvErr_r <= (sel == `UEI_SEL_NONE);
            case (sel)
                `UEI_SEL_ENABLES: prdata_r <= enables_r;
                `UEI_SEL_PENDING: prdata_r <= pendingWord;
                `UEI_SEL_CONTROL: prdata_r <= control_r;
                `UEI_SEL_CLKDET:  prdata_r <= clkDetect_r;
                default:          prdata_r <= `UEI_RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // registered to keep the cpu line free of decode glitches
    always @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(pendingWord & enables_r);
        end
    end

    assign cpuErrorIrq = irq_r;

endmodule // uei_error_irq

/* shared/uei_consts.vh */
// constants for the error interrupt block of the cell port
// assumes inclusion by bare name from the design files
`ifndef UEI_CONSTS_VH
`define UEI_CONSTS_VH

// register byte offsets on the apb bus
`define UEI_OFF_ENABLES 32'h0000_0000
`define UEI_OFF_PENDING 32'h0000_0004
`define UEI_OFF_CONTROL 32'h0000_0008
`define UEI_OFF_CLKDET  32'h0000_000c

// register select codes, one-hot for each register, all zero for an unmapped address
`define UEI_SEL_W       4
`define UEI_SEL_NONE    4'h0
`define UEI_SEL_ENABLES 4'h1
`define UEI_SEL_PENDING 4'h2
`define UEI_SEL_CONTROL 4'h4
`define UEI_SEL_CLKDET  4'h8
`define UEI_SI_ENABLES  0
`define UEI_SI_PENDING  1
`define UEI_SI_CONTROL  2
`define UEI_SI_CLKDET   3

// event bit positions, same in enables and pending
`define UEI_BIT_TX_CP   18
`define UEI_BIT_TX_CF   17
`define UEI_BIT_TX_QS   16
`define UEI_BIT_RX_CP   2
`define UEI_BIT_RX_CF   1
`define UEI_BIT_RX_QS   0
`define UEI_EVENT_MASK  32'h0007_0007

// control register bits
`define UEI_CTRL_RX_EN  0
`define UEI_CTRL_TX_EN  1
`define UEI_CTRL_MASK   32'h0000_0003

// clock detect register fields
`define UEI_CNT_W       8
`define UEI_TXCNT_MSB   23
`define UEI_TXCNT_LSB   16
`define UEI_RXCNT_MSB   7
`define UEI_RXCNT_LSB   0
`define UEI_CLKDET_MASK 32'h00ff_00ff

// reset values and small constants
`define UEI_RST_WORD    32'h0000_0000
`define UEI_CNT_ZERO    8'h00
`define UEI_CNT_ONE     8'h01
`define UEI_DIR_RX      0
`define UEI_DIR_TX      1
`define UEI_NDIR        2

`endif
